// *** bench/rail_supply_model.sv ***
// Purpose: supply and comparator model standing behind each rail enable
// Assumes: an enabled supply ramps to power-good-on after RISE cycles
// Notes:   stall keeps a rail below power-good-on; ov raises the fault flag
`timescale 1ns/10ps
`default_nettype none
module rail_supply_model
	import pwrseq_pkg::*;
#(
	parameter int N    = 4,
	parameter int RISE = 3,
	parameter int FALL = 3
) (
	input  wire logic         clk_in,
	input  wire logic [N-1:0] enable_in,
	input  wire logic [N-1:0] stall_in,
	input  wire logic [N-1:0] ov_in,
	output var rail_mon_t [N-1:0] mon_out
);
	int up_q [N];
	int dn_q [N];

	initial begin
		for (int i = 0; i < N; i++) begin
			up_q[i] = 0;
			dn_q[i] = FALL;
		end
	end

	// ----------------------------------------------------------------
	// ramp counters since the last change of enable
	// ----------------------------------------------------------------
	always @(posedge clk_in) begin
		for (int i = 0; i < N; i++) begin
			up_q[i] <= enable_in[i] ? up_q[i] + 1 : 0;
			if (enable_in[i])
				dn_q[i] <= 0;
			else if (dn_q[i] < FALL)
				dn_q[i] <= dn_q[i] + 1;
		end
	end

	// voltage lies between the limits while ramping either way
	always_comb begin
		for (int i = 0; i < N; i++) begin
			mon_out[i] = '0;
			mon_out[i].pg_on = enable_in[i] && !stall_in[i] && up_q[i] >= RISE;
			mon_out[i].below_pg_off = !enable_in[i] && dn_q[i] >= FALL;
			mon_out[i].ov_fault = ov_in[i];
			mon_out[i].ov_warn = ov_in[i];
		end
	end
endmodule
`default_nettype wire

// *** bench/tb_multi_rail_power_sequencer.sv ***
// Purpose: self-checking bench of the multi-rail power sequencer
// Assumes: 1 ms shortened to 4 clock cycles, four rails
// Notes:   rail0 pin, rail1 op after rail0, rail2 auto, rail3 monitor only
`timescale 1ns/10ps
`default_nettype none
`include "pwrseq_defs.svh"
module tb_multi_rail_power_sequencer
	import pwrseq_pkg::*;
;
	localparam int NR = 4;

	logic                 clk_in;
	logic                 rstn_in;
	logic                 pin;
	logic                 op_on;
	logic                 clr_flt;
	logic                 clr_log;
	logic                 store;
	logic [7:0]           gin;
	logic [NR-1:0]        stall;
	logic [NR-1:0]        ov;
	logic [`TIME_W-1:0]   seq_up_to;
	rail_cfg_t [NR-1:0]   cfg;
	rail_mon_t [NR-1:0]   mon;
	logic [NR-1:0]        enable_out;
	logic [NR-1:0]        power_good_out;
	logic [NR-1:0]        warn;
	logic [NR-1:0][7:0]   rail_fault_status_out;
	logic [7:0]           input_fault_status_out;
	logic [7:0]           common_status_out;
	logic                 log_valid_out;
	logic [3:0]           log_rail_out;
	logic [7:0]           log_bits_out;
	logic                 store_config_out;
	int                   n_errors;
	int                   n_checks;

	multi_rail_power_sequencer #(.NUM_RAILS(NR), .TICK_CYCLES(4))
	u_multi_rail_power_sequencer (
		.clk_in                 (clk_in),
		.rstn_in                (rstn_in),
		.host_sequence_pin_in   (pin),
		.op_on_in               (op_on),
		.clear_faults_in        (clr_flt),
		.log_clear_in           (clr_log),
		.store_config_in        (store),
		.general_input_in       (gin),
		.gpi_fault_mask_in      (8'h01),
		.sequence_up_timeout_in (seq_up_to),
		.cfg_in                 (cfg),
		.mon_in                 (mon),
		.enable_out             (enable_out),
		.power_good_out         (power_good_out),
		.warn_out               (warn),
		.rail_fault_status_out  (rail_fault_status_out),
		.input_fault_status_out (input_fault_status_out),
		.common_status_out      (common_status_out),
		.log_valid_out          (log_valid_out),
		.log_rail_out           (log_rail_out),
		.log_bits_out           (log_bits_out),
		.store_config_out       (store_config_out)
	);

	rail_supply_model #(.N(NR)) u_rail_supply_model (
		.clk_in    (clk_in),
		.enable_in (enable_out),
		.stall_in  (stall),
		.ov_in     (ov),
		.mon_out   (mon)
	);

	initial begin
		clk_in = 1'b0;
		forever #12.5 clk_in = ~clk_in;
	end

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic report_and_stop();
		$display("errors=%0d checks=%0d", n_errors, n_checks);
		if (n_errors == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic step(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask

	function automatic logic probe(input int k, input int r);
		case (k)
			0: return enable_out[r];
			1: return power_good_out[r];
			2: return log_valid_out;
			3: return rail_fault_status_out[r][`FB_RISE];
			5: return rail_fault_status_out[r][`FB_SEQ_UP];
			default: return input_fault_status_out[r];
		endcase
	endfunction

	task automatic wait_for(input int k, input int r, input logic v,
		input int lim);
		int i;
		for (i = 0; i < lim && probe(k, r) !== v; i++)
			step(1);
		n_checks++;
		if (i == lim) begin
			n_errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, probe(k, r), v);
			report_and_stop();
		end
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		n_errors = 0;
		n_checks = 0;
		rstn_in = 1'b0;
		pin = 1'b0;
		op_on = 1'b0;
		clr_flt = 1'b0;
		clr_log = 1'b0;
		store = 1'b0;
		gin = 8'h00;
		stall = '0;
		ov = '0;
		seq_up_to = 12'h000;
		cfg = '0;
		cfg[0].use_pin = 1'b1;
		cfg[0].monitored = 1'b1;
		cfg[0].slaves = 10'h002;
		cfg[0].turn_on_delay = 12'h002;
		cfg[0].max_rise_time_limit = 12'h003;
		cfg[0].max_fall_time_limit = 12'h005;
		cfg[0].resp = RESP_IMMEDIATE;
		cfg[1].use_op = 1'b1;
		cfg[1].monitored = 1'b1;
		cfg[1].parents = 10'h001;
		cfg[1].turn_on_delay = 12'h001;
		cfg[1].turn_off_delay = 12'h001;
		cfg[1].max_rise_time_limit = 12'h008;
		cfg[1].max_fall_time_limit = 12'h005;
		cfg[1].resp = RESP_SEQ_OFF;
		cfg[2].auto_en = 1'b1;
		cfg[3].monitor_only = 1'b1;
		cfg[3].use_pin = 1'b1;
		cfg[3].monitored = 1'b1;
		step(16);
		rstn_in = 1'b1;
		// auto rail comes up with pin and operation both off
		wait_for(1, 2, 1'b1, 20);
		check({4'h0, enable_out}, 8'h04);
		// host raises operation and the control pin
		op_on = 1'b1;
		pin = 1'b1;
		step(3);
		check({7'h0, enable_out[0]}, 8'h00);
		wait_for(0, 0, 1'b1, 40);
		check({7'h0, enable_out[1]}, 8'h00);
		wait_for(1, 0, 1'b1, 40);
		wait_for(0, 1, 1'b1, 40);
		wait_for(1, 1, 1'b1, 40);
		check({4'h0, enable_out}, 8'h07);
		// overvoltage on rail0 while regulating
		ov[0] = 1'b1;
		wait_for(2, 0, 1'b1, 20);
		check({4'h0, log_rail_out}, 8'h00);
		check(log_bits_out, 8'h01);
		check(rail_fault_status_out[0], 8'h01);
		check({4'h0, warn}, 8'h01);
		wait_for(0, 0, 1'b0, 3);
		ov[0] = 1'b0;
		check(common_status_out, 8'h01);
		wait_for(0, 1, 1'b0, 40);
		wait_for(1, 1, 1'b0, 60);
		check({7'h0, enable_out[2]}, 8'h01);
		clr_flt = 1'b1;
		clr_log = 1'b1;
		step(1);
		clr_flt = 1'b0;
		clr_log = 1'b0;
		step(1);
		check(rail_fault_status_out[0], 8'h00);
		check(common_status_out, 8'h00);
		// rail0 re-commanded but never reaches power-good-on
		pin = 1'b0;
		stall[0] = 1'b1;
		step(5);
		pin = 1'b1;
		wait_for(3, 0, 1'b1, 80);
		check({7'h0, log_valid_out}, 8'h01);
		check(log_bits_out, 8'h04);
		wait_for(0, 0, 1'b0, 3);
		gin = 8'h01;
		wait_for(4, 0, 1'b1, 10);
		check(input_fault_status_out, 8'h01);
		// rail1 re-commanded while its parent stays down
		op_on = 1'b0;
		step(2);
		seq_up_to = 12'h001;
		op_on = 1'b1;
		wait_for(5, 1, 1'b1, 20);
		check({4'h0, log_rail_out}, 8'h01);
		check(log_bits_out, 8'h40);
		store = 1'b1;
		step(1);
		store = 1'b0;
		check({7'h0, store_config_out}, 8'h01);
		step(1);
		check({7'h0, store_config_out}, 8'h00);
		report_and_stop();
	end
endmodule
`default_nettype wire

// *** hw/multi_rail_power_sequencer.sv ***
// Purpose: sequences up to ten supply rails on and off and
//          supervises them once in regulation
// Assumes: comparator flags per rail arrive synchronous to clk_in
// Notes:   all times count in 1 ms ticks from a shared divider
`timescale 1ns/10ps
`default_nettype none
`include "pwrseq_defs.svh"
module multi_rail_power_sequencer
	import pwrseq_pkg::*;
#(
	parameter int NUM_RAILS   = `RAILS,
	parameter int TICK_CYCLES = `TICK_CYCLES
) (
	input  wire logic                        clk_in,
	input  wire logic                        rstn_in,
	input  wire logic                        host_sequence_pin_in,
	input  wire logic                        op_on_in,
	input  wire logic                        clear_faults_in,
	input  wire logic                        log_clear_in,
	input  wire logic                        store_config_in,
	input  wire logic [7:0]                  general_input_in,
	input  wire logic [7:0]                  gpi_fault_mask_in,
	input  wire logic [`TIME_W-1:0]          sequence_up_timeout_in,
	input  wire rail_cfg_t [NUM_RAILS-1:0]   cfg_in,
	input  wire rail_mon_t [NUM_RAILS-1:0]   mon_in,
	output logic [NUM_RAILS-1:0]             enable_out,
	output logic [NUM_RAILS-1:0]             power_good_out,
	output logic [NUM_RAILS-1:0]             warn_out,
	output logic [NUM_RAILS-1:0][7:0]        rail_fault_status_out,
	output logic [7:0]                       input_fault_status_out,
	output logic [7:0]                       common_status_out,
	output logic                             log_valid_out,
	output logic [3:0]                       log_rail_out,
	output logic [7:0]                       log_bits_out,
	output logic                             store_config_out
);

	// ------------------------------------------------------------
	// parameter checks
	// ------------------------------------------------------------
	if (NUM_RAILS < 1 || NUM_RAILS > `RAILS) begin : g_bad_rails
		$error("NUM_RAILS out of range");
	end
	if (TICK_CYCLES < 1 || TICK_CYCLES > 65536) begin : g_bad_tick
		$error("TICK_CYCLES out of range");
	end

	localparam rail_st_t RAIL_RST = '{st: ST_OFF, cnt: `CNT_RST,
		en: 1'b0, pg: 1'b0, lock: 1'b0, warn: 1'b0, flt: 8'h00};
	localparam core_t CORE_RST = '{r: {`RAILS{RAIL_RST}},
		default: '0};

	function automatic logic [`TIME_W-1:0] bump(
		input logic [`TIME_W-1:0] c,
		input logic               t
	);
		bump = (t && c != `CNT_SAT) ? c + `TIME_W'(1) : c;
	endfunction

	function automatic logic expired(
		input logic [`TIME_W-1:0] c,
		input logic [`TIME_W-1:0] lim
	);
		expired = (c >= lim);
	endfunction

	core_t                  q;
	core_t                  n;
	logic [`RAILS-1:0]      pgv;
	logic [`RAILS-1:0]      hit_v;
	logic [`RAILS-1:0]      slk_v;
	logic [`RAILS-1:0]      skl_v;
	logic [`RAILS-1:0]      dep_v;
	logic [`RAILS-1:0]      go_v;
	logic [`RAILS-1:0][7:0] fb_v;

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		rail_cfg_t  c;
		rail_mon_t  m;
		rail_st_t   r;
		logic       cmd;
		logic       imm;
		logic       seq;
		logic [7:0] nw;
		c = '0;
		m = '0;
		r = RAIL_RST;
		cmd = 1'b0;
		imm = 1'b0;
		seq = 1'b0;
		nw = 8'h00;
		n = q;
		pgv = '0;
		hit_v = '0;
		slk_v = '0;
		skl_v = '0;
		dep_v = '0;
		go_v = '0;
		fb_v = '0;
		n.tick = (q.div == 16'(TICK_CYCLES - 1));
		n.div = n.tick ? 16'h0000 : q.div + 16'h0001;
		n.store = store_config_in;
		n.log_v = 1'b0;
		n.gin_flt = (q.gin_flt & ~{8{clear_faults_in}})
			| (general_input_in & gpi_fault_mask_in);
		for (int i = 0; i < NUM_RAILS; i++) begin
			pgv[i] = q.r[i].pg;
		end
		// fault detection on each rail
		for (int i = 0; i < NUM_RAILS; i++) begin
			c = cfg_in[i];
			m = mon_in[i];
			r = q.r[i];
			if (r.st == ST_ON && r.pg) begin
				fb_v[i][`FB_OV] = m.ov_fault;
				fb_v[i][`FB_UV] = m.uv_fault;
				fb_v[i][`FB_OC] = m.overcurrent_fault;
				fb_v[i][`FB_UC] = m.undercurrent_fault;
				fb_v[i][`FB_OT] = m.overtemperature_fault;
			end
			// rise time bounded; zero is unbounded
			if (r.st == ST_RISE && c.monitored && !m.pg_on
				&& c.max_rise_time_limit != `CNT_RST
				&& expired(r.cnt, c.max_rise_time_limit)) begin
				fb_v[i][`FB_RISE] = 1'b1;
			end
			hit_v[i] = |fb_v[i];
		end
		// faulted rail shuts its slaves down
		for (int j = 0; j < NUM_RAILS; j++) begin
			for (int i = 0; i < NUM_RAILS; i++) begin
				if (hit_v[i] && cfg_in[i].slaves[j]) begin
					skl_v[j] = 1'b1;
					if (cfg_in[i].resp == RESP_IMMEDIATE
						|| cfg_in[i].resp == RESP_SEQ_OFF) begin
						slk_v[j] = 1'b1;
					end
				end
			end
		end
		// per-rail sequencing
		for (int i = 0; i < NUM_RAILS; i++) begin
			c = cfg_in[i];
			m = mon_in[i];
			r = q.r[i];
			cmd = !c.monitor_only && (c.auto_en
				|| (c.use_pin && host_sequence_pin_in)
				|| (c.use_op && op_on_in));
			dep_v[i] = ((c.parents & ~pgv) == '0)
				&& (!c.gpi_en
				|| general_input_in[c.gpi_sel] == c.gpi_level);
			if (!cmd) begin
				n.r[i].lock = 1'b0;
			end
			// restart and immediate drop at once
			imm = hit_v[i] && (c.resp == RESP_IMMEDIATE
				|| c.resp == RESP_RESTART);
			seq = (hit_v[i] && !imm) || skl_v[i]
				|| !cmd || r.lock;
			if ((hit_v[i] && (c.resp == RESP_IMMEDIATE
				|| c.resp == RESP_SEQ_OFF)) || slk_v[i]) begin
				n.r[i].lock = 1'b1;
			end
			go_v[i] = cmd && !r.lock;
			if (c.monitored) begin
				if (m.below_pg_off) begin
					n.r[i].pg = 1'b0;
				end
				if (r.en && m.pg_on) begin
					n.r[i].pg = 1'b1;
				end
			end
			n.r[i].warn = r.st == ST_ON && r.pg
				&& (m.uv_warn || m.ov_warn);
			case (r.st)
				ST_OFF: begin
					n.r[i].cnt = `CNT_RST;
					// commanded rails (auto, pin or op) start when conditions met
					if (go_v[i] && dep_v[i]) begin
						n.r[i].st = ST_WAIT_ON;
					end else if (go_v[i]) begin
						n.r[i].cnt = bump(r.cnt, q.tick);
						if (sequence_up_timeout_in != `CNT_RST
							&& expired(r.cnt,
							sequence_up_timeout_in)) begin
							fb_v[i][`FB_SEQ_UP] = 1'b1;
						end
					end
				end
				ST_WAIT_ON: begin
					if (!go_v[i] || !dep_v[i]) begin
						n.r[i].st = ST_OFF;
						n.r[i].cnt = `CNT_RST;
					end else if (expired(r.cnt,
						c.turn_on_delay)) begin
						n.r[i].st = ST_RISE;
						n.r[i].en = 1'b1;
						n.r[i].cnt = `CNT_RST;
					end else begin
						n.r[i].cnt = bump(r.cnt, q.tick);
					end
				end
				ST_RISE: begin
					n.r[i].cnt = bump(r.cnt, q.tick);
					if (c.monitored && n.r[i].pg) begin
						n.r[i].st = ST_ON;
					end else if (!c.monitored && expired(r.cnt,
						c.max_rise_time_limit)) begin
						n.r[i].st = ST_ON;
						n.r[i].pg = 1'b1;
					end
				end
				ST_ON: begin
					n.r[i].cnt = `CNT_RST;
				end
				ST_WAIT_OFF: begin
					if (expired(r.cnt, c.turn_off_delay)) begin
						n.r[i].st = ST_FALL;
						n.r[i].en = 1'b0;
						n.r[i].cnt = `CNT_RST;
					end else begin
						n.r[i].cnt = bump(r.cnt, q.tick);
					end
				end
				ST_FALL: begin
					n.r[i].cnt = bump(r.cnt, q.tick);
					if (c.monitored && !n.r[i].pg) begin
						n.r[i].st = ST_OFF;
					end else if (expired(r.cnt,
						c.max_fall_time_limit)) begin
						n.r[i].st = ST_OFF;
						// monitored pg keeps following the off limit
						if (c.monitored) begin
							fb_v[i][`FB_SEQ_DOWN] = 1'b1;
						end else begin
							n.r[i].pg = 1'b0;
						end
					end
				end
				default: begin
					n.r[i] = RAIL_RST;
				end
			endcase
			if (r.en && imm) begin
				n.r[i].st = ST_FALL;
				n.r[i].en = 1'b0;
				n.r[i].cnt = `CNT_RST;
			end else if (r.en && seq && r.st != ST_WAIT_OFF) begin
				n.r[i].st = ST_WAIT_OFF;
				n.r[i].cnt = `CNT_RST;
			end
			// sticky fault byte, a new event beats clear
			n.r[i].flt = (r.flt & ~{8{clear_faults_in}})
				| fb_v[i];
		end
		// lowest rail with a new event is logged
		for (int i = NUM_RAILS - 1; i >= 0; i--) begin
			nw = fb_v[i] & ~q.r[i].flt;
			if (nw != 8'h00) begin
				n.log_v = 1'b1;
				n.log_rail = 4'(i);
				n.log_bits = nw;
			end
		end
		n.log_ne = (q.log_ne && !log_clear_in) || n.log_v;
	end

	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			q <= CORE_RST;
		end else begin
			q <= n;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	always_comb begin
		for (int i = 0; i < NUM_RAILS; i++) begin
			enable_out[i] = q.r[i].en;
			power_good_out[i] = q.r[i].pg;
			warn_out[i] = q.r[i].warn;
			rail_fault_status_out[i] = q.r[i].flt;
		end
		common_status_out = 8'h00;
		common_status_out[`CS_LOG_NE] = q.log_ne;
	end

	assign input_fault_status_out = q.gin_flt;
	assign log_valid_out = q.log_v;
	assign log_rail_out = q.log_rail;
	assign log_bits_out = q.log_bits;
	assign store_config_out = q.store;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rstn_in);

	sequence s_rise_expire;
		q.r[0].st == ST_RISE && cfg_in[0].monitored
			&& !mon_in[0].pg_on && !mon_in[0].below_pg_off
			&& cfg_in[0].max_rise_time_limit != `CNT_RST
			&& q.r[0].cnt >= cfg_in[0].max_rise_time_limit;
	endsequence

	sequence s_rail_shut;
		rail_fault_status_out[0][`FB_RISE]
			&& (q.r[0].st == ST_WAIT_OFF || q.r[0].st == ST_FALL);
	endsequence

	a_on_delay_met: assert property (
		$rose(enable_out[0]) |-> $past(q.r[0].st) == ST_WAIT_ON
			&& $past(q.r[0].cnt) >= $past(cfg_in[0].turn_on_delay))
		else $error("enable raised before turn-on delay");

	a_off_delay_met: assert property (
		$fell(enable_out[0]) && $past(q.r[0].st) == ST_WAIT_OFF
			|-> $past(q.r[0].cnt) >= $past(cfg_in[0].turn_off_delay))
		else $error("enable dropped before turn-off delay");

	for (genvar g = 0; g < NUM_RAILS; g++) begin : g_rail_chk
		a_monitor_only_off: assert property (
			cfg_in[g].monitor_only && q.r[g].st == ST_OFF
				|=> !enable_out[g] && q.r[g].st == ST_OFF)
			else $error("monitor-only rail was sequenced");

		a_auto_start: assert property (
			q.r[g].st == ST_OFF && cfg_in[g].auto_en
				&& !cfg_in[g].monitor_only && !q.r[g].lock
				&& dep_v[g]
				|=> q.r[g].st == ST_WAIT_ON)
			else $error("auto rail did not start");
	end

	a_pg_set: assert property (
		cfg_in[0].monitored && enable_out[0] && mon_in[0].pg_on
			|=> power_good_out[0])
		else $error("power good not set");

	a_pg_hold: assert property (
		power_good_out[0] && cfg_in[0].monitored
			&& !mon_in[0].below_pg_off |=> power_good_out[0])
		else $error("power good lost above off limit");

	a_rise_timeout: assert property (
		s_rise_expire |=> s_rail_shut)
		else $error("rise timeout not flagged or acted on");

	a_zero_unbounded: assert property (
		$rose(rail_fault_status_out[0][`FB_RISE])
			|-> $past(cfg_in[0].max_rise_time_limit) != `CNT_RST)
		else $error("rise fault with unlimited setting");

	a_ov_sticky: assert property (
		rail_fault_status_out[0][`FB_OV] && !clear_faults_in
			|=> rail_fault_status_out[0][`FB_OV])
		else $error("overvoltage bit lost");

	a_log_event: assert property (
		$rose(rail_fault_status_out[0][`FB_OV])
			|-> log_valid_out && log_rail_out == 4'h0)
		else $error("fault event not logged");

	a_store_pulse: assert property (
		store_config_in |=> store_config_out)
		else $error("store request not passed on");

	if (NUM_RAILS > 1) begin : g_slave_chk
		a_slave_off: assert property (
			hit_v[0] && cfg_in[0].slaves[1] && q.r[1].en
				|=> q.r[1].st == ST_WAIT_OFF
				|| q.r[1].st == ST_FALL)
			else $error("fault slave kept running");
	end

endmodule
`default_nettype wire

// *** inc/pwrseq_defs.svh ***
// Purpose: constants of the multi-rail power sequencer
// Assumes: 40 MHz core clock
// Notes:   times in ms are 12-bit fields
`ifndef PWRSEQ_DEFS_SVH
`define PWRSEQ_DEFS_SVH

// ----------------------------------------------------------------
// sizes
// ----------------------------------------------------------------
`define RAILS          10
`define TIME_W         12

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS  25
`define MS_NS          1000000
`define TICK_CYCLES    (`MS_NS / `CLK_PERIOD_NS)
`define MAX_DELAY_MS   3276
`define CNT_RST        12'h000
`define CNT_SAT        12'hfff

// ----------------------------------------------------------------
// rail fault status byte
// ----------------------------------------------------------------
`define FB_OV          0
`define FB_UV          1
`define FB_RISE        2
`define FB_OC          3
`define FB_UC          4
`define FB_OT          5
`define FB_SEQ_UP      6
`define FB_SEQ_DOWN    7

// ----------------------------------------------------------------
// common status byte
// ----------------------------------------------------------------
`define CS_LOG_NE      0

`endif

// *** inc/pwrseq_pkg.sv ***
// Purpose: types of the multi-rail power sequencer
// Assumes: pwrseq_defs.svh on the include path
// Notes:   one-hot rail states
`include "pwrseq_defs.svh"
package pwrseq_pkg;

	typedef enum logic [5:0] {
		ST_OFF      = 6'h01,
		ST_WAIT_ON  = 6'h02,
		ST_RISE     = 6'h04,
		ST_ON       = 6'h08,
		ST_WAIT_OFF = 6'h10,
		ST_FALL     = 6'h20
	} rail_state_t;

	typedef enum logic [1:0] {
		RESP_RESTART   = 2'h0,
		RESP_IMMEDIATE = 2'h1,
		RESP_SEQ_OFF   = 2'h2,
		RESP_GROUP     = 2'h3
	} resp_t;

	typedef struct packed {
		logic                monitor_only;
		logic                auto_en;
		logic                use_op;
		logic                use_pin;
		logic                monitored;
		logic [`RAILS-1:0]   parents;
		logic [`RAILS-1:0]   slaves;
		logic                gpi_en;
		logic [2:0]          gpi_sel;
		logic                gpi_level;
		logic [`TIME_W-1:0]  turn_on_delay;
		logic [`TIME_W-1:0]  turn_off_delay;
		logic [`TIME_W-1:0]  max_rise_time_limit;
		logic [`TIME_W-1:0]  max_fall_time_limit;
		resp_t               resp;
	} rail_cfg_t;

	typedef struct packed {
		logic pg_on;
		logic below_pg_off;
		logic uv_warn;
		logic uv_fault;
		logic ov_warn;
		logic ov_fault;
		logic overcurrent_fault;
		logic undercurrent_fault;
		logic overtemperature_fault;
	} rail_mon_t;

	typedef struct packed {
		rail_state_t         st;
		logic [`TIME_W-1:0]  cnt;
		logic                en;
		logic                pg;
		logic                lock;
		logic                warn;
		logic [7:0]          flt;
	} rail_st_t;

	typedef struct packed {
		rail_st_t [`RAILS-1:0] r;
		logic [15:0]           div;
		logic                  tick;
		logic [7:0]            gin_flt;
		logic                  log_ne;
		logic                  log_v;
		logic [3:0]            log_rail;
		logic [7:0]            log_bits;
		logic                  store;
	} core_t;

endpackage
